// ==== rtl/dsa_pkg.sv ====
// shared constants, enumerations and carriers for the data-space access block
package dsa_pkg;

	// data-space region bases
	localparam logic [9:0] RF_BASE   = 10'h000;
	localparam logic [9:0] IO_BASE   = 10'h020;
	localparam logic [9:0] SRAM_BASE = 10'h060;

	// i/o register offsets (i/o instruction addresses)
	localparam logic [5:0] IO_NVM_STAT    = 6'h12;
	localparam logic [5:0] IO_GPR0        = 6'h13;
	localparam logic [5:0] IO_GPR1        = 6'h14;
	localparam logic [5:0] IO_GPR2        = 6'h15;
	localparam logic [5:0] IO_NVM_CTRL    = 6'h1C;
	localparam logic [5:0] IO_NVM_DATA    = 6'h1D;
	localparam logic [5:0] IO_NVM_ADDR_LO = 6'h1E;
	localparam logic [5:0] IO_NVM_ADDR_HI = 6'h1F;
	localparam logic [5:0] IO_BIT_LIMIT   = 6'h20;

	// control register field positions
	localparam int CTRL_READ = 0;
	localparam int CTRL_PROG = 1;
	localparam int CTRL_MPE  = 2;
	localparam int CTRL_RIE  = 3;
	localparam int CTRL_MODE = 4;

	// programming mode codes
	localparam logic [1:0] MODE_ATOMIC = 2'h0;
	localparam logic [1:0] MODE_ERASE  = 2'h1;
	localparam logic [1:0] MODE_WRITE  = 2'h2;
	localparam logic [1:0] MODE_RSVD   = 2'h3;

	// pointer pair low registers
	localparam logic [4:0] PTR_X = 5'h1A;

	// apb byte addresses above the data-space window
	localparam logic [12:0] APB_CMD    = 13'h1000;
	localparam logic [12:0] APB_RESULT = 13'h1004;

	// cycle counts
	localparam logic [2:0] MPE_CYCLES  = 3'h4;
	localparam logic [2:0] STALL_READ  = 3'h4;
	localparam logic [2:0] STALL_PROG  = 3'h2;

	// programming times and the calibrated oscillator rate
	localparam real T_ATOMIC_MS = 3.4;
	localparam real T_SPLIT_MS  = 1.8;
	localparam real OSC_KHZ     = 8000.0;

	typedef enum logic [2:0] {
		OP_LD, OP_ST, OP_IN, OP_OUT, OP_SBI, OP_CBI, OP_IO_BIT_TEST_SET_INSTR
	} dsa_op_e;

	typedef enum logic [2:0] {
		AM_DIRECT, AM_IND, AM_DISP, AM_PREDEC, AM_POSTINC
	} dsa_am_e;

	typedef enum logic [1:0] {S_IDLE, S_WAIT, S_DONE} dsa_state_e;

	// command word written to APB_CMD
	typedef struct packed {
		logic [2:0] bitsel;
		logic [9:0] addr;
		logic [4:0] rg;
		logic [5:0] disp;
		logic [1:0] ptr;
		dsa_am_e    amode;
		dsa_op_e    op;
	} dsa_cmd_s;

	// one data-space write
	typedef struct packed {
		logic       en;
		logic [7:0] data;
		logic [7:0] mask;
	} dsa_wr_s;

endpackage : dsa_pkg

// ==== rtl/dsa_prog_timer.sv ====
// programming timer counting synchronised ticks of the calibrated oscillator
`timescale 1ns/1ps
module dsa_prog_timer #(
	parameter int ATOMIC_TICKS = 27200,
	parameter int SPLIT_TICKS  = 14400
) (
	// clock and power-on reset
	input  wire logic clk,
	input  wire logic power_on_n,
	// oscillator tick from its own domain
	input  wire logic osc_tick,
	// control
	input  wire logic start,
	input  wire logic long_op,
	// status
	output logic      busy,
	output logic      done
);
	localparam int TW = $clog2(ATOMIC_TICKS + 1);

	logic          tick_meta_q;
	logic          tick_sync_q;
	logic          tick_old_q;
	logic [TW-1:0] cnt_q;
	logic          busy_q;
	logic          done_q;
	wire           tick_edge = tick_sync_q & ~tick_old_q;

	// only the power-on reset stops a running operation
	always_ff @(posedge clk or negedge power_on_n)
	begin
		if (!power_on_n)
		begin
			tick_meta_q <= 1'b0;
			tick_sync_q <= 1'b0;
			tick_old_q  <= 1'b0;
			cnt_q       <= '0;
			busy_q      <= 1'b0;
			done_q      <= 1'b0;
		end
		else
		begin
			tick_meta_q <= osc_tick;
			tick_sync_q <= tick_meta_q;
			tick_old_q  <= tick_sync_q;
			done_q      <= 1'b0;
			if (start)
			begin
				cnt_q  <= long_op ? TW'(ATOMIC_TICKS) : TW'(SPLIT_TICKS);
				busy_q <= 1'b1;
			end
			else if (busy_q && tick_edge)
			begin
				cnt_q <= cnt_q - TW'(1);
				if (cnt_q == TW'(1))
				begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
			end
		end
	end

	assign busy = busy_q;
	assign done = done_q;

endmodule : dsa_prog_timer

// ==== rtl/dsa_data_space.sv ====
// data-space decode, pointer addressing and data eeprom controller
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
module dsa_data_space #(
	parameter int SRAM_BYTES   = 256,
	parameter int NVM_BYTES    = 256,
	parameter int ATOMIC_TICKS =
		int'($ceil(dsa_pkg::T_ATOMIC_MS * dsa_pkg::OSC_KHZ)),
	parameter int SPLIT_TICKS  =
		int'($ceil(dsa_pkg::T_SPLIT_MS * dsa_pkg::OSC_KHZ))
) (
	// clock and resets
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        power_on_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [12:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// calibrated oscillator tick
	input  wire logic        osc_tick,
	// eeprom status
	output logic             nvm_busy
);
	localparam int DS_TOP = int'(dsa_pkg::SRAM_BASE) + SRAM_BYTES;
	localparam int SAW    = $clog2(SRAM_BYTES);
	localparam int NAW    = $clog2(NVM_BYTES);

	// storage
	logic [7:0] rf_q   [32];
	logic [7:0] sram_q [SRAM_BYTES];
	logic [7:0] nvm_q  [NVM_BYTES];
	logic [7:0] gpr_q  [3];

	// bus state
	dsa_pkg::dsa_state_e st_q, st_d;
	logic [2:0]  cnt_q, cnt_d;
	logic        pready_q, pready_d;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic [8:0]  result_q;

	// eeprom control state
	logic        mpe_q;
	logic [2:0]  mpe_cnt_q;
	logic        rie_q;
	logic        done_q;
	logic [7:0]  nvm_byte_data_q;
	logic [8:0]  ear_q;
	logic [1:0]  mode_q;
	logic [8:0]  pa_q;
	logic [7:0]  pd_q;
	logic [1:0]  pm_q;
	logic        rst_meta_q;
	logic        rst_sync_q;
	logic        busy;
	logic        prog_done;

	// request decode
	dsa_pkg::dsa_cmd_s cmd;
	dsa_pkg::dsa_wr_s  wr;
	logic [9:0]  mem_a;
	logic [7:0]  io_rd;
	wire         acc     = psel & penable;
	wire         is_ds   = (paddr[12:2] < 11'(DS_TOP)) & (paddr[1:0] == 2'h0);
	wire         is_cmd  = paddr == dsa_pkg::APB_CMD;
	wire         is_res  = paddr == dsa_pkg::APB_RESULT;
	wire         mapped  = is_ds | is_cmd | is_res;
	wire         do_cmd  = is_cmd & pwrite;
	wire         commit  = st_q == dsa_pkg::S_DONE;
	assign cmd = dsa_pkg::dsa_cmd_s'(pwdata);

	// pointer pair selection
	// pairs X, Y, Z
	wire [4:0]  ptr_idx = 5'(dsa_pkg::PTR_X + {2'h0, cmd.ptr, 1'b0});
	wire [4:0]  ptr_hi  = 5'(ptr_idx + 5'h01);
	wire [15:0] ptr_val = {rf_q[ptr_hi], rf_q[ptr_idx]};
	wire [15:0] ptr_dec = 16'(ptr_val - 16'h0001);
	wire [15:0] ptr_inc = 16'(ptr_val + 16'h0001);
	wire        is_mem  = (cmd.op == dsa_pkg::OP_LD)
			| (cmd.op == dsa_pkg::OP_ST);
	wire        is_io   = (cmd.op == dsa_pkg::OP_IN)
			| (cmd.op == dsa_pkg::OP_OUT);
	wire        ptr_upd = is_mem & ((cmd.amode == dsa_pkg::AM_PREDEC)
			| (cmd.amode == dsa_pkg::AM_POSTINC));
	wire [15:0] ptr_new = (cmd.amode == dsa_pkg::AM_PREDEC)
			? ptr_dec : ptr_inc;

	// effective address per addressing mode
	always_comb
	begin
		case (cmd.amode)
			dsa_pkg::AM_DIRECT:  mem_a = cmd.addr;
			dsa_pkg::AM_IND:     mem_a = ptr_val[9:0];
			// displacement only off Y or Z
			dsa_pkg::AM_DISP:    mem_a = (cmd.ptr != 2'h0)
				? 10'(ptr_val + {10'h000, cmd.disp}) : ptr_val[9:0];
			dsa_pkg::AM_PREDEC:  mem_a = ptr_dec[9:0];
			dsa_pkg::AM_POSTINC: mem_a = ptr_val[9:0];
			default:             mem_a = ptr_val[9:0];
		endcase
	end

	wire [9:0] io_a  = 10'(dsa_pkg::IO_BASE + {4'h0, cmd.addr[5:0]});
	wire [9:0] eff_a = !do_cmd ? paddr[11:2] : is_mem ? mem_a : io_a;
	wire       in_rf   = eff_a < dsa_pkg::IO_BASE;
	wire       in_io   = ~in_rf & (eff_a < dsa_pkg::SRAM_BASE);
	wire       in_sram = ~in_rf & ~in_io & (eff_a < 10'(DS_TOP));
	wire [5:0] io_off  = 6'(eff_a - dsa_pkg::IO_BASE);
	wire [SAW-1:0] sram_idx = SAW'(eff_a - dsa_pkg::SRAM_BASE);
	// bit instructions limited to low i/o
	wire       bit_ok  = cmd.addr[5:0] < dsa_pkg::IO_BIT_LIMIT;
	wire [7:0] bit_m   = 8'h01 << cmd.bitsel;

	// i/o read mux, reserved bits read zero
	always_comb
	begin
		case (io_off)
			dsa_pkg::IO_NVM_STAT:    io_rd = {7'h00, done_q};
			dsa_pkg::IO_GPR0:        io_rd = gpr_q[0];
			dsa_pkg::IO_GPR1:        io_rd = gpr_q[1];
			dsa_pkg::IO_GPR2:        io_rd = gpr_q[2];
			dsa_pkg::IO_NVM_CTRL:    io_rd = {2'h0, mode_q, rie_q,
				mpe_q, busy, 1'b0};
			dsa_pkg::IO_NVM_DATA:    io_rd = nvm_byte_data_q;
			dsa_pkg::IO_NVM_ADDR_LO: io_rd = ear_q[7:0];
			dsa_pkg::IO_NVM_ADDR_HI: io_rd = {7'h00, ear_q[8]};
			default:                 io_rd = 8'h00;
		endcase
	end

	wire [7:0] rd_val = in_rf ? rf_q[eff_a[4:0]] : in_io ? io_rd
			: in_sram ? sram_q[sram_idx] : 8'h00;

	// write request built from bus or command
	always_comb
	begin
		wr = '{en: 1'b0, data: 8'h00, mask: 8'hFF};
		if (is_ds && pwrite)
			wr = '{en: 1'b1, data: pwdata[7:0], mask: 8'hFF};
		else if (do_cmd)
		begin
			unique case (cmd.op)
				dsa_pkg::OP_ST, dsa_pkg::OP_OUT:
					wr = '{en: 1'b1, data: rf_q[cmd.rg], mask: 8'hFF};
				dsa_pkg::OP_SBI:
					wr = '{en: bit_ok, data: bit_m, mask: bit_m};
				dsa_pkg::OP_CBI:
					wr = '{en: bit_ok, data: 8'h00, mask: bit_m};
				default:
					wr = '{en: 1'b0, data: 8'h00, mask: 8'hFF};
			endcase
		end
	end

	// write decode at commit
	wire       wr_go   = commit & wr.en;
	wire       io_wr   = wr_go & in_io;
	wire [7:0] trig    = wr.data & wr.mask;
	wire       ctrl_wr = io_wr & (io_off == dsa_pkg::IO_NVM_CTRL);
	wire       ld_go   = commit & do_cmd & ((cmd.op == dsa_pkg::OP_LD)
			| (cmd.op == dsa_pkg::OP_IN));
	// strobe taken as the transfer is accepted so the enable window holds
	wire       pe_trig = (st_q == dsa_pkg::S_IDLE) & acc & wr.en & in_io
			& (io_off == dsa_pkg::IO_NVM_CTRL) & trig[dsa_pkg::CTRL_PROG];
	wire       re_trig = ctrl_wr & trig[dsa_pkg::CTRL_READ];
	wire       mpe_set = ctrl_wr & trig[dsa_pkg::CTRL_MPE];
	wire       mpe_clr = ctrl_wr & wr.mask[dsa_pkg::CTRL_MPE]
			& ~wr.data[dsa_pkg::CTRL_MPE];
	wire [7:0] ctrl_new = (io_rd & ~wr.mask) | trig;
	wire       prog_start = pe_trig & mpe_q & ~busy
			& (mode_q != dsa_pkg::MODE_RSVD);

	wire       ctrl_hit = wr.en & in_io & (io_off == dsa_pkg::IO_NVM_CTRL);
	wire [2:0] stall = (ctrl_hit & trig[dsa_pkg::CTRL_READ])
			? dsa_pkg::STALL_READ
			: (ctrl_hit & trig[dsa_pkg::CTRL_PROG])
			? dsa_pkg::STALL_PROG : 3'h0;

	// bus handshake sequencing
	always_comb
	begin
		st_d     = st_q;
		cnt_d    = cnt_q;
		pready_d = 1'b0;
		unique case (st_q)
			dsa_pkg::S_IDLE:
				if (acc)
				begin
					if (stall == 3'h0)
					begin
						st_d     = dsa_pkg::S_DONE;
						pready_d = 1'b1;
					end
					else
					begin
						st_d  = dsa_pkg::S_WAIT;
						cnt_d = stall;
					end
				end
			dsa_pkg::S_WAIT:
			begin
				cnt_d = 3'(cnt_q - 3'h1);
				if (cnt_q == 3'h1)
				begin
					st_d     = dsa_pkg::S_DONE;
					pready_d = 1'b1;
				end
			end
			dsa_pkg::S_DONE:
				st_d = dsa_pkg::S_IDLE;
		endcase
	end

	// bus registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_q      <= dsa_pkg::S_IDLE;
			cnt_q     <= 3'h0;
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else
		begin
			st_q     <= st_d;
			cnt_q    <= cnt_d;
			pready_q <= pready_d;
			if (pready_d)
			begin
				prdata_q  <= (is_ds && !pwrite) ? {24'h000000, rd_val}
					: (is_res && !pwrite) ? {23'h000000, result_q}
					: 32'h0000_0000;
				pslverr_q <= ~mapped;
			end
		end
	end

	// command results and i/o control registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			result_q  <= 9'h000;
			mpe_q     <= 1'b0;
			mpe_cnt_q <= 3'h0;
			rie_q     <= 1'b0;
			done_q    <= 1'b0;
			nvm_byte_data_q    <= 8'h00;
			ear_q     <= 9'h000;
			gpr_q     <= '{8'h00, 8'h00, 8'h00};
		end
		else
		begin
			if (commit && do_cmd)
				result_q <= {(cmd.op == dsa_pkg::OP_IO_BIT_TEST_SET_INSTR) & bit_ok
					& rd_val[cmd.bitsel], rd_val};
			if (mpe_set)
			begin
				mpe_q     <= 1'b1;
				mpe_cnt_q <= dsa_pkg::MPE_CYCLES;
			end
			else if (mpe_clr || mpe_cnt_q == 3'h1)
			begin
				mpe_q     <= 1'b0;
				mpe_cnt_q <= 3'h0;
			end
			else if (mpe_cnt_q != 3'h0)
				mpe_cnt_q <= 3'(mpe_cnt_q - 3'h1);
			if (ctrl_wr)
				rie_q <= ctrl_new[dsa_pkg::CTRL_RIE];
			// write one clears, completion set wins
			if (prog_done)
				done_q <= 1'b1;
			else if (io_wr && io_off == dsa_pkg::IO_NVM_STAT && trig[0])
				done_q <= 1'b0;
			// read only when idle, data ready at once
			if (re_trig && !busy)
				nvm_byte_data_q <= nvm_q[NAW'(ear_q)];
			else if (io_wr && io_off == dsa_pkg::IO_NVM_DATA)
				nvm_byte_data_q <= ctrl_new;
			if (io_wr && !busy && io_off == dsa_pkg::IO_NVM_ADDR_LO)
				ear_q <= 9'(NVM_BYTES - 1) & {ear_q[8], ctrl_new};
			if (io_wr && !busy && io_off == dsa_pkg::IO_NVM_ADDR_HI)
				ear_q <= 9'(NVM_BYTES - 1) & {ctrl_new[0], ear_q[7:0]};
			if (io_wr && io_off >= dsa_pkg::IO_GPR0
				&& io_off <= dsa_pkg::IO_GPR2)
				gpr_q[2'(io_off - dsa_pkg::IO_GPR0)] <= ctrl_new;
		end
	end

	// register file and sram, no reset as in real storage
	always_ff @(posedge clk)
	begin
		if (wr_go && in_rf)
			rf_q[eff_a[4:0]] <= wr.data;
		if (wr_go && in_sram)
			sram_q[sram_idx] <= wr.data;
		if (ld_go)
			rf_q[cmd.rg] <= rd_val;
		if (commit && do_cmd && ptr_upd)
		begin
			rf_q[ptr_idx] <= ptr_new[7:0];
			rf_q[ptr_hi]  <= ptr_new[15:8];
		end
	end

	always_ff @(posedge clk or negedge power_on_n)
	begin
		if (!power_on_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
			mode_q     <= dsa_pkg::MODE_ATOMIC;
			pa_q       <= 9'h000;
			pd_q       <= 8'h00;
			pm_q       <= dsa_pkg::MODE_ATOMIC;
		end
		else
		begin
			rst_meta_q <= reset_n;
			rst_sync_q <= rst_meta_q;
			if (!rst_sync_q && !busy)
				mode_q <= dsa_pkg::MODE_ATOMIC;
			else if (ctrl_wr && !busy)
				mode_q <= ctrl_new[dsa_pkg::CTRL_MODE +: 2];
			if (prog_start)
			begin
				pa_q <= ear_q;
				pd_q <= nvm_byte_data_q;
				pm_q <= mode_q;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (prog_done)
			nvm_q[NAW'(pa_q)] <= (pm_q == dsa_pkg::MODE_ERASE) ? 8'hFF
				: (pm_q == dsa_pkg::MODE_WRITE) ? (nvm_q[NAW'(pa_q)] & pd_q)
				: pd_q;
	end

	dsa_prog_timer #(
		.ATOMIC_TICKS (ATOMIC_TICKS),
		.SPLIT_TICKS  (SPLIT_TICKS)
	) u_timer (
		.clk        (clk),
		.power_on_n (power_on_n),
		.osc_tick   (osc_tick),
		.start      (prog_start),
		.long_op    (mode_q == dsa_pkg::MODE_ATOMIC),
		.busy       (busy),
		.done       (prog_done)
	);

	assign prdata   = prdata_q;
	assign pready   = pready_q;
	assign pslverr  = pslverr_q;
	assign nvm_busy = busy;

	// checks on the guarded behaviour
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_quiet2;
		!pready_q [*2];
	endsequence
	sequence s_quiet4;
		!pready_q [*4];
	endsequence

	a_sram_two_cycles: assert property (
		(st_q == dsa_pkg::S_IDLE && acc && stall == 3'h0) |=> pready_q)
		else $error("plain access not answered in two cycles");
	a_read_stall_four: assert property (
		(st_q == dsa_pkg::S_IDLE && acc && stall == dsa_pkg::STALL_READ)
		|=> s_quiet4 ##1 pready_q)
		else $error("read strobe stall is not four cycles");
	a_prog_stall_two: assert property (
		(st_q == dsa_pkg::S_IDLE && acc && stall == dsa_pkg::STALL_PROG)
		|=> s_quiet2 ##1 pready_q)
		else $error("program strobe stall is not two cycles");
	a_mpe_self_clear: assert property (
		(mpe_set && !mpe_q) |=> mpe_q [*4] ##1 !mpe_q)
		else $error("master enable did not lapse after four cycles");
	a_no_start_busy: assert property (
		prog_start |-> !busy)
		else $error("programming started while busy");
	a_mode_frozen: assert property (
		(busy && $past(busy)) |-> $stable(mode_q))
		else $error("mode changed during programming");
	a_rsvd_no_op: assert property (
		(pe_trig && !busy && mode_q == dsa_pkg::MODE_RSVD) |=> !busy)
		else $error("reserved mode started programming");
	a_addr_frozen: assert property (
		(busy && $past(busy)) |-> $stable(ear_q))
		else $error("eeprom address changed during programming");
	a_flag_set_wins: assert property (
		prog_done |=> done_q)
		else $error("completion flag lost");
	a_strobe_reads_busy: assert property (
		prog_start |=> busy [*2])
		else $error("program strobe dropped early");

endmodule : dsa_data_space

// ==== verification/dsa_cpu_model.sv ====
// cpu stand-in: apb master transfers and the calibrated oscillator tick
`timescale 1ns/1ps
module dsa_cpu_model (
	// clock
	input  wire logic        clk,
	// apb master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [12:0] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	// oscillator tick, unrelated in phase to clk
	output logic             osc_tick
);
	// idle bus and a slow tick so programming spans many transfers
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 13'h0000;
		pwdata = 32'h00000000;
		osc_tick = 1'b0;
	end

	always #733 osc_tick = ~osc_tick;

	// one transfer; cyc counts access cycles up to and incl. pready
	task automatic xfer(input logic wr, input logic [12:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic err,
		output int cyc);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		cyc = 0;
		// look at pready off the edge, take the answer at the edge
		do
		begin
			@(negedge clk);
			cyc++;
		end
		while (pready !== 1'b1);
		@(posedge clk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines show no stale value
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : dsa_cpu_model

// ==== verification/test_data_space_eeprom_access.sv ====
// self-checking bench for the data-space access block
`timescale 1ns/1ps
module test_data_space_eeprom_access;
	localparam logic [12:0] A_CTRL = 13'h00F0;
	localparam logic [12:0] A_DATA = 13'h00F4;
	localparam logic [12:0] A_ALO  = 13'h00F8;
	localparam logic [12:0] A_GPR0 = 13'h00CC;
	localparam logic [12:0] A_DONE = 13'h00C8;
	localparam logic [12:0] A_CMD  = 13'h1000;
	localparam logic [12:0] A_RES  = 13'h1004;

	logic        clk, reset_n, power_on_n, psel, penable, pwrite;
	logic        pready, pslverr, osc_tick, nvm_busy, err;
	logic [12:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int          cyc, fail_count, checks_done;

	dsa_data_space #(.SRAM_BYTES(256), .NVM_BYTES(256),
		.ATOMIC_TICKS(5), .SPLIT_TICKS(3)) i_dut (
		.clk, .reset_n, .power_on_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .osc_tick, .nvm_busy);

	dsa_cpu_model i_cpu (
		.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .osc_tick);

	// 10 mhz clock
	always #50 clk = ~clk;

	task automatic chk(input string n, input logic [31:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [12:0] a, input logic [31:0] d);
		i_cpu.xfer(1'b1, a, d, q, err, cyc);
	endtask : wr

	task automatic rd(input logic [12:0] a);
		i_cpu.xfer(1'b0, a, 32'h00000000, q, err, cyc);
	endtask : rd

	// command word: op, mode, pointer, reg, addr, bit, displacement
	function automatic logic [31:0] cmd(input logic [2:0] op, am,
		input logic [1:0] p, input logic [4:0] r, input logic [9:0] a,
		input logic [2:0] b, input logic [5:0] dp);
		return {b, a, r, dp, p, am, op};
	endfunction : cmd

	task automatic wait_idle;
		int n;
		n = 0;
		while (nvm_busy !== 1'b0 && n < 600)
		begin
			@(posedge clk);
			n++;
		end
		if (nvm_busy !== 1'b0)
		begin
			fail_count++;
			$display("Error nvm_busy expected 0 seen %b", nvm_busy);
		end
	endtask : wait_idle

	task automatic prog(input logic [1:0] m, input logic [7:0] d,
		input logic w);
		wr(A_DATA, {24'h000000, d});
		wr(A_CTRL, {26'h0000000, m, 4'h4});
		wr(A_CTRL, {26'h0000000, m, 4'h2});
		chk("prog stall", 32'h00000004, cyc);
		if (w)
			wait_idle();
	endtask : prog

	task automatic t_map;
		logic [12:0] a [3];
		a = '{13'h007C, 13'h00CC, 13'h0180};
		foreach (a[i])
		begin
			wr(a[i], 32'hA0 + i);
			rd(a[i]);
			chk("space", 32'hA0 + i, q);
			chk("access cycles", 32'h00000002, cyc);
		end
		wr(A_CMD, cmd(3'h2, 3'h0, 2'h0, 5'h03, 10'h013, 3'h0, 6'h00));
		rd(13'h000C);
		chk("io view", 32'h000000A1, q);
		wr(A_CMD, cmd(3'h3, 3'h0, 2'h0, 5'h03, 10'h014, 3'h0, 6'h00));
		rd(13'h00D0);
		chk("out view", 32'h000000A1, q);
		rd(13'h1800);
		chk("unmapped", 32'h00000001, {31'h0, err});
	endtask : t_map

	task automatic t_ptr;
		wr(13'h0008, 32'h00000077);
		wr(13'h0070, 32'h00000070);
		wr(13'h0074, 32'h00000000);
		wr(A_CMD, cmd(3'h1, 3'h3, 2'h1, 5'h02, 10'h000, 3'h0, 6'h00));
		rd(13'h0070);
		chk("ptr after predec", 32'h0000006F, q);
		rd(13'h01BC);
		chk("predec store", 32'h00000077, q);
		wr(13'h02B8, 32'h00000099);
		wr(A_CMD, cmd(3'h0, 3'h2, 2'h1, 5'h04, 10'h000, 3'h0, 6'h3F));
		rd(13'h0010);
		chk("disp load", 32'h00000099, q);
		wr(A_CMD, cmd(3'h0, 3'h1, 2'h1, 5'h05, 10'h000, 3'h0, 6'h00));
		rd(13'h0014);
		chk("ind load", 32'h00000077, q);
		wr(13'h0068, 32'h00000060);
		wr(13'h006C, 32'h00000000);
		wr(A_CMD, cmd(3'h1, 3'h4, 2'h0, 5'h02, 10'h000, 3'h0, 6'h00));
		rd(13'h0068);
		chk("ptr after postinc", 32'h00000061, q);
		rd(13'h0180);
		chk("postinc store", 32'h00000077, q);
	endtask : t_ptr

	task automatic t_bits;
		wr(A_GPR0, 32'h000000F0);
		wr(A_CMD, cmd(3'h4, 3'h0, 2'h0, 5'h00, 10'h013, 3'h0, 6'h00));
		wr(A_CMD, cmd(3'h5, 3'h0, 2'h0, 5'h00, 10'h013, 3'h7, 6'h00));
		rd(A_GPR0);
		chk("bit ops", 32'h00000071, q);
		wr(A_CMD, cmd(3'h6, 3'h0, 2'h0, 5'h00, 10'h013, 3'h4, 6'h00));
		rd(A_RES);
		chk("bit test", 32'h00000100, q & 32'h00000100);
	endtask : t_bits

	// probes made while an atomic write is still running
	task automatic busy_chk;
		chk("busy", 32'h00000001, {31'h0, nvm_busy});
		rd(A_CTRL);
		chk("strobe held", 32'h00000002, q & 32'h00000002);
		wr(A_ALO, 32'h00000055);
		wr(A_CTRL, 32'h00000010);
		wr(A_CTRL, 32'h00000001);
		rd(A_DATA);
		chk("read blocked", 32'h000000A5, q);
		wait_idle();
		rd(A_ALO);
		chk("addr kept", 32'h000000FC, q);
		rd(A_CTRL);
		chk("mode kept", 32'h00000000, q & 32'h00000030);
		rd(A_DONE);
		chk("done flag", 32'h00000001, q & 32'h00000001);
		wr(A_DONE, 32'h00000001);
		rd(A_DONE);
		chk("done clear", 32'h00000000, q & 32'h00000001);
	endtask : busy_chk

	task automatic t_nvm;
		logic [7:0] ex [4];
		ex = '{8'hA5, 8'hFF, 8'hA5, 8'h3C};
		for (int m = 0; m < 4; m++)
		begin
			wr(A_ALO, 32'hFC + m);
			prog(2'h0, 8'h3C, 1'b1);
			if (m == 2)
				prog(2'h1, 8'h00, 1'b1);
			prog(2'(m), 8'hA5, m != 0);
			if (m == 0)
				busy_chk();
			wr(A_CTRL, 32'h00000001);
			chk("read stall", 32'h00000006, cyc);
			rd(A_DATA);
			chk("nvm byte", {24'h0, ex[m]}, q);
		end
		wr(A_CTRL, 32'h00000004);
		repeat (5) @(posedge clk);
		wr(A_CTRL, 32'h00000002);
		rd(A_CTRL);
		chk("late strobe", 32'h00000000, q & 32'h00000002);
	endtask : t_nvm

	task automatic t_reset;
		wr(A_ALO, 32'h00000040);
		prog(2'h0, 8'h81, 1'b0);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		chk("busy over reset", 32'h00000001, {31'h0, nvm_busy});
		wait_idle();
		wr(A_ALO, 32'h00000040);
		wr(A_CTRL, 32'h00000001);
		rd(A_DATA);
		chk("kept write", 32'h00000081, q);
	endtask : t_reset

	task automatic results;
		$display("checks %0d errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	// watchdog well beyond the expected thousand or so cycles
	initial
	begin
		#3000000;
		fail_count++;
		results();
	end

	initial
	begin
		clk = 1'b0;
		reset_n = 1'b0;
		power_on_n = 1'b0;
		fail_count = 0;
		checks_done = 0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		power_on_n <= 1'b1;
		t_map();
		t_ptr();
		t_bits();
		t_nvm();
		t_reset();
		results();
	end
endmodule : test_data_space_eeprom_access
